// File: mcs_pkg.sv
// shared constants and types for the core programmer-visible state block
// assumes a single core clock and a synchronous active-high reset
package mcs_pkg;

   // special register area, reached by direct address only
   localparam logic [7:0]  MCS_SFR_ACC    = 8'hE0;
   localparam logic [7:0]  MCS_SFR_B      = 8'hF0;
   localparam logic [7:0]  MCS_SFR_SP     = 8'h81;
   localparam logic [7:0]  MCS_SFR_DPL    = 8'h82;
   localparam logic [7:0]  MCS_SFR_DPH    = 8'h83;
   localparam logic [7:0]  MCS_SFR_PSW    = 8'hD0;
   localparam logic [7:0]  MCS_UNMAPPED   = 8'h00;

   // reset values
   localparam logic [7:0]  MCS_SP_RESET   = 8'h07;
   localparam logic [15:0] MCS_PC_RESET   = 16'h0000;
   localparam logic [7:0]  MCS_ACC_RESET  = 8'h00;
   localparam logic [7:0]  MCS_B_RESET    = 8'h00;
   localparam logic [15:0] MCS_EXTERNAL_POINTER_RESET = 16'h0000;
   localparam logic [6:0]  MCS_PSW_RESET  = 7'h00;

   // fixed interrupt entries: base plus source times eight
   localparam logic [15:0] MCS_VEC_BASE   = 16'h0003;
   localparam int          MCS_VEC_SHIFT  = 3;

   // bit-addressable byte area
   localparam logic [7:0]  MCS_BIT_BASE   = 8'h20;

   // status word field positions
   localparam int MCS_PSW_CY  = 7;
   localparam int MCS_PSW_AC  = 6;
   localparam int MCS_PSW_F0  = 5;
   localparam int MCS_PSW_RS1 = 4;
   localparam int MCS_PSW_RS0 = 3;
   localparam int MCS_PSW_OV  = 2;
   localparam int MCS_PSW_F1  = 1;
   localparam int MCS_PSW_P   = 0;

   typedef enum logic [4:0] {
      MCS_NOP, MCS_DIR_WR, MCS_DIR_RD, MCS_IND_WR, MCS_IND_RD,
      MCS_REG_WR, MCS_REG_RD, MCS_BIT_SET, MCS_BIT_CLR, MCS_BIT_RD,
      MCS_ADD, MCS_ADDC, MCS_SUBB, MCS_RLC, MCS_RRC, MCS_MUL, MCS_DIV,
      MCS_PUSH, MCS_POP, MCS_CALL, MCS_INT, MCS_RET, MCS_FETCH,
      MCS_JUMP, MCS_EXTERNAL_POINTER_LD, MCS_XRD, MCS_XWR
   } mcs_cmd_t;

   typedef struct packed {
      mcs_cmd_t    cmd;
      logic [7:0]  addr;
      logic [7:0]  data;
      logic [15:0] target;
   } mcs_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } mcs_xbus_t;

endpackage : mcs_pkg

// File: mcs_alu.sv
// eight-bit adder with carry, half carry and signed range flags
// subtraction adds the inverted operand; carry in and out mean "no borrow"
`timescale 1ns/1ps
module mcs_alu
   import mcs_pkg::*;
(
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   input  wire logic       sub,
   output logic [7:0]      res,
   output logic            cy,
   output logic            ac,
   output logic            ov
);
   logic [7:0] bx;
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   always_comb begin
      bx       = sub ? ~b : b;
      low_sum  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
      full_sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
      res      = full_sum[7:0];
      cy       = full_sum[8];
      ac       = low_sum[4];
      ov       = (a[7] == bx[7]) && (full_sum[7] != a[7]);
   end
endmodule : mcs_alu

// File: mcs_core_state.sv
// programmer-visible state of the eight-bit core: registers, status word,
// internal RAM with banks, bit area and stack, program counter and vectors
// assumes one command per taken request from the sequencer on the same clock
// Operation
// - separate 64K code and data spaces, fetch code-only
// - flash writes only during programming or update
// - special registers reached by direct address only
// - accumulator eight bits, pairs with B
// - B holds multiply and divide operand/result
// - stack index increments before each push
// - stack index resets to 07h
// - stack spans all 256 RAM bytes
// - program counter sixteen bits, reset zero
// - first fetch after reset at 0000h
// - interrupts jump to eight-byte spaced vectors
// - carry takes ALU carry, shifts, rotates
// - half carry from bit three
// - two bank bits pick register bank
// - overflow on signed result out of range
// - parity keeps accumulator plus flag even
// - sixteen-bit external pointer addresses data memory
// - four eight-register banks in bytes 0-31
// - bytes 32-47 give 128 addressable bits
`timescale 1ns/1ps
module mcs_core_state
   import mcs_pkg::*;
#(
   parameter int RAM_BYTES = 256
)(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire mcs_req_t   req,
   input  wire logic       req_valid,
   input  wire logic       flash_update,
   input  wire logic       xdata_is_flash,
   input  wire logic [7:0] xdata_rdata,
   output logic            req_ready,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output logic [15:0]     code_addr,
   output logic            code_rd,
   output mcs_xbus_t       xbus,
   output logic            write_refused,
   output logic [7:0]      accumulator_reg,
   output logic [7:0]      multiply_operand_reg,
   output logic [7:0]      stack_index,
   output logic [15:0]     next_instr,
   output logic [15:0]     external_pointer,
   output logic [7:0]      status_word
);
   typedef enum logic [1:0] {ST_IDLE, ST_PUSH_HI, ST_POP_LO} mcs_state_t;

   logic [7:0]  ram [RAM_BYTES];
   mcs_state_t  state, next_state;
   logic [15:0] hold, next_hold;
   logic [6:0]  flags, next_flags;
   logic        parity, next_parity;
   logic [7:0]  next_acc, next_b, next_sp, next_rd_data;
   logic [15:0] next_pc, next_external_pointer, next_code_addr;
   logic        next_rd_valid, next_code_rd, next_refused, next_ready;
   mcs_xbus_t   next_xbus;
   logic        ram_we;
   logic [7:0]  ram_waddr, ram_wdata;
   logic [7:0]  bank_base, ptr, bit_byte, sp_up, sfr_rd;
   logic [15:0] product;
   logic        take;
   logic [7:0]  alu_res;
   logic        alu_cy, alu_ac, alu_ov, alu_cin, alu_sub;

   mcs_alu u_alu (
      .a   (accumulator_reg),
      .b   (req.data),
      .cin (alu_cin),
      .sub (alu_sub),
      .res (alu_res),
      .cy  (alu_cy),
      .ac  (alu_ac),
      .ov  (alu_ov)
   );

   always_comb begin
      take      = req_valid && req_ready;
      bank_base = {3'b000, flags[MCS_PSW_RS1-1], flags[MCS_PSW_RS0-1], 3'b000};
      ptr       = ram[bank_base | {7'h00, req.addr[0]}];
      bit_byte  = MCS_BIT_BASE + {4'h0, req.addr[6:3]};
      sp_up     = stack_index + 8'h01;
      product   = accumulator_reg * multiply_operand_reg;
      alu_sub   = (req.cmd == MCS_SUBB);
      alu_cin   = (req.cmd == MCS_ADD) ? 1'b0 : flags[MCS_PSW_CY-1];
      case (req.addr)
         MCS_SFR_ACC: sfr_rd = accumulator_reg;
         MCS_SFR_B:   sfr_rd = multiply_operand_reg;
         MCS_SFR_SP:  sfr_rd = stack_index;
         MCS_SFR_DPL: sfr_rd = external_pointer[7:0];
         MCS_SFR_DPH: sfr_rd = external_pointer[15:8];
         MCS_SFR_PSW: sfr_rd = status_word;
         default:     sfr_rd = MCS_UNMAPPED;
      endcase
   end

   always_comb begin
      next_state     = state;
      next_hold      = hold;
      next_flags     = flags;
      next_acc       = accumulator_reg;
      next_b         = multiply_operand_reg;
      next_sp        = stack_index;
      next_pc        = next_instr;
      next_external_pointer      = external_pointer;
      next_code_addr = code_addr;
      next_rd_data   = rd_data;
      next_rd_valid  = 1'b0;
      next_code_rd   = 1'b0;
      next_refused   = 1'b0;
      next_xbus      = '{addr: external_pointer, wdata: accumulator_reg, we: 1'b0, re: 1'b0};
      ram_we         = 1'b0;
      ram_waddr      = 8'h00;
      ram_wdata      = 8'h00;
      case (state)
         ST_IDLE: begin
            if (take) begin
               case (req.cmd)
                  MCS_DIR_WR: begin
                     if (!req.addr[7]) begin
                        ram_we    = 1'b1;
                        ram_waddr = req.addr;
                        ram_wdata = req.data;
                     end else begin
                        case (req.addr)
                           MCS_SFR_ACC: next_acc = req.data;
                           MCS_SFR_B:   next_b = req.data;
                           MCS_SFR_SP:  next_sp = req.data;
                           MCS_SFR_DPL: next_external_pointer[7:0] = req.data;
                           MCS_SFR_DPH: next_external_pointer[15:8] = req.data;
                           MCS_SFR_PSW: next_flags = req.data[7:1];
                           default:     next_refused = 1'b1;
                        endcase
                     end
                  end
                  MCS_DIR_RD: begin
                     next_rd_data  = req.addr[7] ? sfr_rd : ram[req.addr];
                     next_rd_valid = 1'b1;
                  end
                  MCS_IND_WR: begin
                     // upper half through a pointer is plain RAM, never a special register
                     ram_we    = 1'b1;
                     ram_waddr = ptr;
                     ram_wdata = req.data;
                  end
                  MCS_IND_RD: begin
                     next_rd_data  = ram[ptr];
                     next_rd_valid = 1'b1;
                  end
                  MCS_REG_WR: begin
                     ram_we    = 1'b1;
                     ram_waddr = bank_base | {5'h00, req.addr[2:0]};
                     ram_wdata = req.data;
                  end
                  MCS_REG_RD: begin
                     next_rd_data  = ram[bank_base | {5'h00, req.addr[2:0]}];
                     next_rd_valid = 1'b1;
                  end
                  MCS_BIT_SET, MCS_BIT_CLR: begin
                     if (req.addr[7]) begin
                        next_refused = 1'b1;
                     end else begin
                        ram_we    = 1'b1;
                        ram_waddr = bit_byte;
                        ram_wdata = ram[bit_byte];
                        ram_wdata[req.addr[2:0]] = (req.cmd == MCS_BIT_SET);
                     end
                  end
                  MCS_BIT_RD: begin
                     next_rd_data  = {7'h00, ram[bit_byte][req.addr[2:0]] & ~req.addr[7]};
                     next_rd_valid = 1'b1;
                     next_refused  = req.addr[7];
                  end
                  MCS_ADD, MCS_ADDC, MCS_SUBB: begin
                     next_acc                 = alu_res;
                     next_flags[MCS_PSW_CY-1] = alu_cy;
                     next_flags[MCS_PSW_AC-1] = alu_ac;
                     next_flags[MCS_PSW_OV-1] = alu_ov;
                  end
                  MCS_RLC: begin
                     next_acc                 = {accumulator_reg[6:0], flags[MCS_PSW_CY-1]};
                     next_flags[MCS_PSW_CY-1] = accumulator_reg[7];
                  end
                  MCS_RRC: begin
                     next_acc                 = {flags[MCS_PSW_CY-1], accumulator_reg[7:1]};
                     next_flags[MCS_PSW_CY-1] = accumulator_reg[0];
                  end
                  MCS_MUL: begin
                     next_acc                 = product[7:0];
                     next_b                   = product[15:8];
                     next_flags[MCS_PSW_CY-1] = 1'b0;
                     next_flags[MCS_PSW_OV-1] = (product[15:8] != 8'h00);
                  end
                  MCS_DIV: begin
                     // a zero divisor leaves both operands and flags overflow
                     next_flags[MCS_PSW_CY-1] = 1'b0;
                     next_flags[MCS_PSW_OV-1] = (multiply_operand_reg == 8'h00);
                     if (multiply_operand_reg != 8'h00) begin
                        next_acc = accumulator_reg / multiply_operand_reg;
                        next_b   = accumulator_reg % multiply_operand_reg;
                     end
                  end
                  MCS_PUSH: begin
                     next_sp   = sp_up;
                     ram_we    = 1'b1;
                     ram_waddr = sp_up;
                     ram_wdata = req.data;
                  end
                  MCS_POP: begin
                     next_rd_data  = ram[stack_index];
                     next_rd_valid = 1'b1;
                     next_sp       = stack_index - 8'h01;
                  end
                  MCS_CALL, MCS_INT: begin
                     next_sp    = sp_up;
                     ram_we     = 1'b1;
                     ram_waddr  = sp_up;
                     ram_wdata  = next_instr[7:0];
                     next_hold  = (req.cmd == MCS_CALL) ? req.target :
                                  MCS_VEC_BASE + ({14'h0000, req.addr[1:0]} << MCS_VEC_SHIFT);
                     next_state = ST_PUSH_HI;
                  end
                  MCS_RET: begin
                     next_hold  = {ram[stack_index], 8'h00};
                     next_sp    = stack_index - 8'h01;
                     next_state = ST_POP_LO;
                  end
                  MCS_FETCH: begin
                     next_code_addr = next_instr;
                     next_code_rd   = 1'b1;
                     next_pc        = next_instr + 16'h0001;
                  end
                  MCS_JUMP:    next_pc   = req.target;
                  MCS_EXTERNAL_POINTER_LD: next_external_pointer = req.target;
                  MCS_XRD: begin
                     next_acc     = xdata_rdata;
                     next_xbus.re = 1'b1;
                  end
                  MCS_XWR: begin
                     if (!xdata_is_flash || flash_update) begin
                        next_xbus.we = 1'b1;
                     end else begin
                        next_refused = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
         ST_PUSH_HI: begin
            next_sp    = sp_up;
            ram_we     = 1'b1;
            ram_waddr  = sp_up;
            ram_wdata  = next_instr[15:8];
            next_pc    = hold;
            next_state = ST_IDLE;
         end
         ST_POP_LO: begin
            next_pc    = {hold[15:8], ram[stack_index]};
            next_sp    = stack_index - 8'h01;
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      next_ready  = (next_state == ST_IDLE);
      next_parity = ^next_acc;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state                <= ST_IDLE;
         hold                 <= MCS_PC_RESET;
         flags                <= MCS_PSW_RESET;
         parity               <= 1'b0;
         accumulator_reg      <= MCS_ACC_RESET;
         multiply_operand_reg <= MCS_B_RESET;
         stack_index          <= MCS_SP_RESET;
         next_instr           <= MCS_PC_RESET;
         external_pointer     <= MCS_EXTERNAL_POINTER_RESET;
         code_addr            <= MCS_PC_RESET;
         code_rd              <= 1'b0;
         rd_data              <= 8'h00;
         rd_valid             <= 1'b0;
         write_refused        <= 1'b0;
         req_ready            <= 1'b0;
         xbus                 <= '{addr: MCS_EXTERNAL_POINTER_RESET, wdata: MCS_ACC_RESET, we: 1'b0, re: 1'b0};
      end else begin
         state                <= next_state;
         hold                 <= next_hold;
         flags                <= next_flags;
         parity               <= next_parity;
         accumulator_reg      <= next_acc;
         multiply_operand_reg <= next_b;
         stack_index          <= next_sp;
         next_instr           <= next_pc;
         external_pointer     <= next_external_pointer;
         code_addr            <= next_code_addr;
         code_rd              <= next_code_rd;
         rd_data              <= next_rd_data;
         rd_valid             <= next_rd_valid;
         write_refused        <= next_refused;
         req_ready            <= next_ready;
         xbus                 <= next_xbus;
      end
   end

   // memory has no reset: contents are undefined until software writes them
   always_ff @(posedge clk) begin
      if (ram_we) begin
         ram[ram_waddr] <= ram_wdata;
      end
   end

   assign status_word = {flags, parity};
endmodule : mcs_core_state

// File: mcs_core_state_chk.sv
// checker for the core state block: ties outputs to the commands taken
// sees only the top module ports; bound to every instance below
`timescale 1ns/1ps
module mcs_core_state_chk
   import mcs_pkg::*;
#(
   parameter int RAM_BYTES = 256
)(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire mcs_req_t   req,
   input wire logic       req_valid,
   input wire logic       flash_update,
   input wire logic       xdata_is_flash,
   input wire logic [7:0] xdata_rdata,
   input wire logic       req_ready,
   input wire logic [7:0] rd_data,
   input wire logic       rd_valid,
   input wire logic [15:0] code_addr,
   input wire logic       code_rd,
   input wire mcs_xbus_t  xbus,
   input wire logic       write_refused,
   input wire logic [7:0] accumulator_reg,
   input wire logic [7:0] multiply_operand_reg,
   input wire logic [7:0] stack_index,
   input wire logic [15:0] next_instr,
   input wire logic [15:0] external_pointer,
   input wire logic [7:0] status_word
);
   logic        take;
   logic [15:0] tgt;
   logic [15:0] int_vec;
   logic        locked;

   assign take    = req_valid && req_ready;
   assign tgt     = req.target;
   assign int_vec = 16'h0003 + {11'h000, req.addr[1:0], 3'h0};
   assign locked  = xdata_is_flash && !flash_update;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_sp_rst; $fell(sys_rst) |-> stack_index == 8'h07; endproperty
   a_sp_rst: assert property (p_sp_rst) else $error("stack index not 07h after reset");
   property p_pc_rst; $fell(sys_rst) |-> next_instr == 16'h0000; endproperty
   a_pc_rst: assert property (p_pc_rst) else $error("program counter not zero after reset");
   property p_fetch;
      take && req.cmd == MCS_FETCH |=> code_rd && code_addr == $past(next_instr)
         && next_instr == $past(next_instr) + 16'h0001;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address or counter step wrong");
   property p_push; take && req.cmd == MCS_PUSH |=> stack_index == $past(stack_index) + 8'h01; endproperty
   a_push: assert property (p_push) else $error("push did not pre-increment stack index");
   property p_call;
      take && req.cmd == MCS_CALL |=> !req_ready ##1
         (next_instr == $past(tgt, 2) && stack_index == $past(stack_index, 2) + 8'h02);
   endproperty
   a_call: assert property (p_call) else $error("call target or stack depth wrong");
   property p_int; take && req.cmd == MCS_INT |=> ##1 next_instr == $past(int_vec, 2); endproperty
   a_int: assert property (p_int) else $error("interrupt entry address wrong");
   property p_par; status_word[0] == ^accumulator_reg; endproperty
   a_par: assert property (p_par) else $error("parity flag out of step with accumulator");
   property p_bit_ref; take && req.cmd == MCS_BIT_SET && req.addr[7] |=> write_refused; endproperty
   a_bit_ref: assert property (p_bit_ref) else $error("bit op on special area not refused");
   property p_flash; take && req.cmd == MCS_XWR && locked |=> write_refused && !xbus.we; endproperty
   a_flash: assert property (p_flash) else $error("flash write went through outside update");
   property p_xwr;
      take && req.cmd == MCS_XWR && !locked |=> xbus.we && xbus.addr == external_pointer;
   endproperty
   a_xwr: assert property (p_xwr) else $error("external write strobe or address wrong");
   property p_mul;
      take && req.cmd == MCS_MUL |=>
         {multiply_operand_reg, accumulator_reg} == $past(accumulator_reg) * $past(multiply_operand_reg);
   endproperty
   a_mul: assert property (p_mul) else $error("product not split over B and accumulator");
   property p_rd; take && req.cmd == MCS_DIR_RD |=> rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("direct read gave no result pulse");
endmodule : mcs_core_state_chk

bind mcs_core_state mcs_core_state_chk #(.RAM_BYTES(RAM_BYTES)) chk_u (
   .clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .flash_update(flash_update),
   .xdata_is_flash(xdata_is_flash), .xdata_rdata(xdata_rdata), .req_ready(req_ready), .rd_data(rd_data),
   .rd_valid(rd_valid), .code_addr(code_addr), .code_rd(code_rd), .xbus(xbus), .write_refused(write_refused),
   .accumulator_reg(accumulator_reg), .multiply_operand_reg(multiply_operand_reg), .stack_index(stack_index),
   .next_instr(next_instr), .external_pointer(external_pointer), .status_word(status_word));

// File: mcu_core_state_and_memory_map_tb_top.sv
// self-checking bench for the core state block: command rows, then hand tests
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
module mcu_core_state_and_memory_map_tb_top
   import mcs_pkg::*;
;
   typedef struct packed {mcs_cmd_t c; logic [7:0] a; logic [7:0] d; logic [7:0] e;} mcs_row_t;
   logic        clk, sys_rst, req_valid, flash_update, xdata_is_flash, req_ready, rd_valid, code_rd, write_refused;
   mcs_req_t    req;
   mcs_xbus_t   xbus;
   logic [7:0]  xdata_rdata, rd_data, accumulator_reg, multiply_operand_reg, stack_index, status_word;
   logic [15:0] code_addr, next_instr, external_pointer;
   int          fails, samples_checked, cycles;
   logic [15:0] vec [4] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B};
   mcs_row_t    rows [$] = '{
      '{MCS_DIR_WR,8'hD0,8'h08,8'h00}, '{MCS_REG_WR,8'h05,8'hA5,8'h00}, '{MCS_DIR_RD,8'h0D,8'h00,8'hA5},
      '{MCS_DIR_WR,8'hD0,8'h10,8'h00}, '{MCS_REG_WR,8'h07,8'h3C,8'h00}, '{MCS_DIR_RD,8'h17,8'h00,8'h3C},
      '{MCS_DIR_WR,8'hD0,8'h18,8'h00}, '{MCS_REG_WR,8'h05,8'h5A,8'h00}, '{MCS_DIR_RD,8'h1D,8'h00,8'h5A},
      '{MCS_DIR_WR,8'hD0,8'h00,8'h00}, '{MCS_REG_WR,8'h00,8'hC3,8'h00}, '{MCS_DIR_RD,8'h00,8'h00,8'hC3},
      '{MCS_DIR_WR,8'h21,8'h00,8'h00}, '{MCS_BIT_SET,8'h0B,8'h00,8'h00}, '{MCS_DIR_WR,8'h2F,8'h00,8'h00},
      '{MCS_BIT_SET,8'h7F,8'h00,8'h00}, '{MCS_DIR_RD,8'h21,8'h00,8'h08}, '{MCS_DIR_RD,8'h2F,8'h00,8'h80},
      '{MCS_DIR_WR,8'hE0,8'h7F,8'h00}, '{MCS_ADD,8'h00,8'h01,8'h00}, '{MCS_DIR_RD,8'hD0,8'h00,8'h45},
      '{MCS_SUBB,8'h00,8'h01,8'h00}, '{MCS_DIR_RD,8'hE0,8'h00,8'h7E}, '{MCS_DIR_RD,8'hD0,8'h00,8'h84},
      '{MCS_RLC,8'h00,8'h00,8'h00}, '{MCS_DIR_RD,8'hE0,8'h00,8'hFD},
      '{MCS_RRC,8'h00,8'h00,8'h00}, '{MCS_DIR_RD,8'hE0,8'h00,8'h7E},
      '{MCS_DIR_WR,8'hF0,8'h10,8'h00}, '{MCS_DIR_WR,8'hE0,8'h34,8'h00}, '{MCS_MUL,8'h00,8'h00,8'h00},
      '{MCS_DIR_RD,8'hF0,8'h00,8'h03}, '{MCS_DIR_RD,8'hE0,8'h00,8'h40},
      '{MCS_DIR_WR,8'hE0,8'h64,8'h00}, '{MCS_DIR_WR,8'hF0,8'h07,8'h00}, '{MCS_DIV,8'h00,8'h00,8'h00},
      '{MCS_DIR_RD,8'hE0,8'h00,8'h0E}, '{MCS_DIR_RD,8'hF0,8'h00,8'h02},
      '{MCS_DIR_WR,8'h81,8'h2F,8'h00}, '{MCS_PUSH,8'h00,8'h99,8'h00}, '{MCS_DIR_RD,8'h30,8'h00,8'h99},
      '{MCS_POP,8'h00,8'h00,8'h99}, '{MCS_DIR_RD,8'h81,8'h00,8'h2F}, '{MCS_DIR_WR,8'h81,8'hFE,8'h00},
      '{MCS_PUSH,8'h00,8'h77,8'h00}, '{MCS_REG_WR,8'h00,8'hFF,8'h00}, '{MCS_IND_RD,8'h00,8'h00,8'h77},
      '{MCS_DIR_WR,8'h82,8'h34,8'h00}, '{MCS_DIR_WR,8'h83,8'h12,8'h00}, '{MCS_DIR_RD,8'h83,8'h00,8'h12},
      '{MCS_DIR_RD,8'h82,8'h00,8'h34}, '{MCS_DIR_RD,8'h90,8'h00,8'h00}};

   mcs_core_state #(.RAM_BYTES(256)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid), .flash_update(flash_update),
      .xdata_is_flash(xdata_is_flash), .xdata_rdata(xdata_rdata), .req_ready(req_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .code_addr(code_addr), .code_rd(code_rd), .xbus(xbus), .write_refused(write_refused),
      .accumulator_reg(accumulator_reg), .multiply_operand_reg(multiply_operand_reg), .stack_index(stack_index),
      .next_instr(next_instr), .external_pointer(external_pointer), .status_word(status_word));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // valid stays up after the take so back-to-back requests need no gap; idle drops it
   task automatic issue(input mcs_cmd_t c, input logic [7:0] a, input logic [7:0] d, input logic [15:0] t);
      req       = '{c, a, d, t};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
   endtask : issue

   task automatic idle;
      req_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask : idle

   initial begin
      {sys_rst, req_valid, flash_update, xdata_is_flash} = 4'h8;
      req         = '0;
      xdata_rdata = 8'hA5;
      repeat (4) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      foreach (rows[i]) begin
         issue(rows[i].c, rows[i].a, rows[i].d, 16'h0000);
         if (rows[i].c inside {MCS_DIR_RD, MCS_IND_RD, MCS_POP}) begin
            chk($sformatf("row %0d valid", i), 16'(rd_valid), 16'h0001);
            chk($sformatf("row %0d data", i), 16'(rd_data), 16'(rows[i].e));
         end
      end
      xdata_is_flash = 1'b1;
      issue(MCS_EXTERNAL_POINTER_LD, 8'h00, 8'h00, 16'h8000);
      issue(MCS_DIR_WR, 8'hE0, 8'hC6, 16'h0000);
      issue(MCS_XWR, 8'h00, 8'h00, 16'h0000);
      chk("flash refused", 16'({write_refused, xbus.we}), 16'h0002);
      flash_update = 1'b1;
      issue(MCS_XWR, 8'h00, 8'h00, 16'h0000);
      chk("xwr strobe", 16'(xbus.we), 16'h0001);
      chk("xwr addr", xbus.addr, 16'h8000);
      chk("xwr data", 16'(xbus.wdata), 16'h00C6);
      issue(MCS_XRD, 8'h00, 8'h00, 16'h0000);
      chk("xrd strobe", 16'(xbus.re), 16'h0001);
      chk("xrd acc", 16'(accumulator_reg), 16'h00A5);
      {xdata_is_flash, flash_update} = 2'b00;
      issue(MCS_BIT_SET, 8'h85, 8'h00, 16'h0000);
      chk("bit special refused", 16'(write_refused), 16'h0001);
      issue(MCS_DIR_WR, 8'h90, 8'h55, 16'h0000);
      chk("unmapped refused", 16'(write_refused), 16'h0001);
      issue(MCS_DIR_WR, 8'h81, 8'h07, 16'h0000);
      issue(MCS_JUMP, 8'h00, 8'h00, 16'h0456);
      issue(MCS_CALL, 8'h00, 8'h00, 16'h1234);
      chk("call busy", 16'(req_ready), 16'h0000);
      idle();
      chk("call pc", next_instr, 16'h1234);
      chk("call sp", 16'(stack_index), 16'h0009);
      issue(MCS_DIR_RD, 8'h08, 8'h00, 16'h0000);
      chk("pushed low", 16'(rd_data), 16'h0056);
      issue(MCS_DIR_RD, 8'h09, 8'h00, 16'h0000);
      chk("pushed high", 16'(rd_data), 16'h0004);
      for (int s = 0; s < 4; s++) begin
         issue(MCS_INT, 8'(s), 8'h00, 16'h0000);
         idle();
         chk($sformatf("vector %0d", s), next_instr, vec[s]);
      end
      issue(MCS_RET, 8'h00, 8'h00, 16'h0000);
      idle();
      chk("ret pc", next_instr, 16'h0013);
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("rst sp", 16'(stack_index), 16'h0007);
      chk("rst pc", next_instr, 16'h0000);
      sys_rst = 1'b0;
      issue(MCS_FETCH, 8'h00, 8'h00, 16'h0000);
      chk("first fetch", {code_addr[14:0], code_rd}, 16'h0001);
      chk("pc step", next_instr, 16'h0001);
      wrap_up();
   end
endmodule : mcu_core_state_and_memory_map_tb_top
